// >>> verilog/pxu_top.sv
// Purpose: Exception recognition and entry for an embedded RISC core
// Assumes: Pipeline presents one instruction per ex_valid pulse and waits for ex_ack_q
// Notes: Answer comes one cycle after ex_valid; a faulting instruction must not commit
//
// Function
// (RQ1) Misaligned word or halfword access raises an address error.
// (RQ2) User-mode reference with address top bit set raises an address error.
// (RQ3) Address error code: load/fetch code or store code.
// (RQ4) Address error captures offending address in faulting address register.
// (RQ5) Return pointer gets faulting pc, or branch pc plus delay flag.
// (RQ6) Entry shifts mode stack and clears current kernel/user and enable.
// (RQ7) Synchronous exceptions ignore masks and enables.
// (RQ8) Every exception goes to the single general vector.
// (RQ9) Trap instruction raises exception with trap code.
// (RQ10) Operand bits 25..6 of the trap instruction are ignored.
// (RQ11) Bus error input during a read raises a bus error exception.
// (RQ12) Bus error code: fetch code or data code.
// (RQ13) External logic reports asynchronous write errors through interrupts.
// (RQ14) Coprocessor op on unusable unit traps; unit zero usable in kernel.
// (RQ15) Unusable exception records the code and the referenced unit number.
// (RQ16) Eight sources, each masked by its bit, all masked by enable.
// (RQ17) Interrupt writes its code; cause shows all pending sources.
// (RQ18) Software interrupt bits are writable: one pends, zero clears.
// (RQ19) External interrupt requests stay asserted until cleared at source.
// (RQ20) No context save beyond the stack; a second exception overwrites.
// (RQ21) Return-from-exception pops the mode stack.
// (RQ22) Faulting instruction and later ones do not update architectural state.
// (RQ23) Interrupt requested only if enabled and a pending source unmasked.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pxu_top (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Instruction in the exception stage
   input wire logic ex_valid,
   input wire logic [31:0] ex_pc,
   input wire logic [31:0] ex_instr,
   input wire logic ex_in_delay_slot,
   input wire logic [31:0] ex_branch_pc,
   // Data access of that instruction
   input wire logic ex_mem_rd,
   input wire logic ex_mem_wr,
   input wire logic [1:0] ex_mem_size,
   input wire logic [31:0] ex_mem_addr,
   // Read activity of the bus unit
   input wire logic rd_fetch_active,
   input wire logic rd_data_active,
   // External pins
   input wire logic bus_err_n,
   input wire logic [5:0] hw_irq_n,
   // Answer to the pipeline
   output logic ex_ack_q,
   output logic ex_fault_q,
   output logic [31:0] redirect_pc_q,
   output logic user_mode_q,
   output logic irq_request_q,
   // Software register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q
);
   typedef struct packed {
      logic [3:0] cu;
      logic [7:0] im;
      logic [5:0] kuie;
      logic bd;
      logic [1:0] ce;
      logic [1:0] sw;
      logic [4:0] code;
      logic [31:0] exception_return_pointer;
      logic [31:0] badva;
      logic be_fetch;
      logic be_data;
      logic ack;
      logic fault;
      logic [31:0] redirect;
      logic irq_req;
      logic [31:0] rdata;
   } pxu_state_t;

   pxu_state_t st_q;
   pxu_state_t st_d;

   // Synchronised pin view
   logic [6:0] pin_lvl;
   logic [5:0] hw_pend;
   logic bus_err;

   // Address checks and current mode
   logic fetch_bad;
   logic data_bad;
   logic user_mode;

   // Interrupt view
   logic [7:0] pend_all;
   logic irq_take;

   // Decode of the instruction in the stage
   logic is_trap;
   logic is_cop;
   logic is_rfe;
   logic [1:0] cop_unit;
   logic cop_unusable;

   // Exception selected for this instruction
   logic take;
   logic [4:0] take_code;
   logic take_badva;
   logic [31:0] badva_val;

   // Readback images
   logic [31:0] status_word;
   logic [31:0] cause_word;

   // Trap decode looks only at opcode and function fields
   function automatic logic dec_trap(input logic [31:0] ins);
      dec_trap = (ins[31:26] == pxu_pkg::OP_SPECIAL) && (ins[5:0] == pxu_pkg::FN_TRAP); // RQ10
   endfunction

   // Coprocessor instruction decode
   function automatic logic dec_cop(input logic [31:0] ins);
      dec_cop = (ins[31:28] == pxu_pkg::OP_COP_HI);
   endfunction

   // Return-from-exception decode
   function automatic logic dec_rfe(input logic [31:0] ins);
      dec_rfe = (ins[31:26] == pxu_pkg::OP_COP0) && ins[25] && (ins[5:0] == pxu_pkg::FN_RETURN);
   endfunction

   // Interrupt and bus error pins, active low, idle high
   // Bus error shares the synchroniser so all pins see the same latency
   pxu_sync #(
      .WIDTH(pxu_pkg::NUM_PINS),
      .RST_VAL(7'h7F)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin_in({bus_err_n, hw_irq_n}),
      .level_out(pin_lvl)
   );

   assign hw_pend = ~pin_lvl[5:0]; // RQ19
   assign bus_err = ~pin_lvl[6];
   assign user_mode = st_q.kuie[pxu_pkg::KU_CUR];

   // Fetch address always checked as a word
   pxu_addr_chk u_fetch_chk (
      .vaddr(ex_pc),
      .size(pxu_pkg::SIZE_WORD),
      .user_mode(user_mode),
      .bad(fetch_bad)
   );

   // Data address checked at the access size
   pxu_addr_chk u_data_chk (
      .vaddr(ex_mem_addr),
      .size(ex_mem_size),
      .user_mode(user_mode),
      .bad(data_bad)
   );

   // Pending sources and the interrupt request
   always_comb begin
      pend_all = {hw_pend, st_q.sw}; // RQ16
      irq_take = st_q.kuie[pxu_pkg::IE_CUR] && ((pend_all & st_q.im) != 8'h00); // RQ16 RQ23
   end

   // Instruction decode for the exception stage
   always_comb begin
      is_trap = dec_trap(ex_instr);
      is_cop = dec_cop(ex_instr);
      is_rfe = dec_rfe(ex_instr);
      cop_unit = ex_instr[27:26];
      // Unit zero is always usable in kernel mode
      // A return instruction decodes as a unit-zero op and so never traps in kernel mode
      cop_unusable = is_cop && !st_q.cu[cop_unit] && !((cop_unit == 2'h0) && !user_mode); // RQ14
   end

   // Priority select of the exception taken on this instruction
   always_comb begin
      take = 1'b0;
      take_code = pxu_pkg::CODE_INT;
      take_badva = 1'b0;
      badva_val = ex_pc;
      if (ex_valid) begin
         // Only the interrupt branch depends on mask or enable bits
         // Fetch faults lead because nothing else about that word can be trusted
         if (fetch_bad) begin // RQ7
            take = 1'b1;
            take_code = pxu_pkg::CODE_LOAD_FETCH_MISALIGN; // RQ3
            take_badva = 1'b1;
            badva_val = ex_pc; // RQ4
         end else if (st_q.be_fetch) begin
            take = 1'b1;
            take_code = pxu_pkg::CODE_FETCH_BUS_ERR; // RQ12
         end else if (irq_take) begin
            take = 1'b1;
            take_code = pxu_pkg::CODE_INT; // RQ17
         end else if (cop_unusable) begin
            take = 1'b1;
            take_code = pxu_pkg::CODE_UNIT_UNUSABLE; // RQ15
         end else if (is_trap) begin
            take = 1'b1;
            take_code = pxu_pkg::CODE_TRAP; // RQ9
         end else if ((ex_mem_rd || ex_mem_wr) && data_bad) begin
            take = 1'b1;
            take_code = ex_mem_wr ? pxu_pkg::CODE_STORE_MISALIGN : pxu_pkg::CODE_LOAD_FETCH_MISALIGN; // RQ3
            take_badva = 1'b1;
            badva_val = ex_mem_addr; // RQ4
         end else if (st_q.be_data) begin
            take = 1'b1;
            take_code = pxu_pkg::CODE_DATA_BUS_ERR; // RQ12
         end
      end
   end

   // Readback images of status and cause
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[pxu_pkg::ST_CU_LSB +: 4] = st_q.cu;
      status_word[pxu_pkg::ST_IM_LSB +: 8] = st_q.im;
      status_word[pxu_pkg::ST_KUIE_LSB +: 6] = st_q.kuie;
      cause_word = 32'h0000_0000;
      cause_word[pxu_pkg::CA_BD_POS] = st_q.bd;
      cause_word[pxu_pkg::CA_CE_LSB +: 2] = st_q.ce;
      cause_word[pxu_pkg::CA_IP_LSB +: 6] = hw_pend; // RQ17
      cause_word[pxu_pkg::CA_SW_LSB +: 2] = st_q.sw; // RQ17
      cause_word[pxu_pkg::CA_CODE_LSB +: 5] = st_q.code;
   end

   // Next-state logic
   always_comb begin
      st_d = st_q;
      st_d.ack = ex_valid;
      st_d.fault = 1'b0;
      st_d.irq_req = irq_take; // RQ23

      // Bus error during a read is held until the stage consumes it
      // Clear comes before set, so an error in the consuming cycle is kept
      if (ex_valid) begin
         st_d.be_fetch = 1'b0;
         st_d.be_data = 1'b0;
      end
      if (bus_err && rd_fetch_active) begin
         st_d.be_fetch = 1'b1; // RQ11
      end
      if (bus_err && rd_data_active) begin
         st_d.be_data = 1'b1; // RQ11
      end

      // Software writes; status first, exception entry may override below
      if (reg_wr) begin
         unique case (reg_addr)
            pxu_pkg::ADDR_STATUS: begin
               st_d.cu = reg_wdata[pxu_pkg::ST_CU_LSB +: 4];
               st_d.im = reg_wdata[pxu_pkg::ST_IM_LSB +: 8];
               st_d.kuie = reg_wdata[pxu_pkg::ST_KUIE_LSB +: 6];
            end
            pxu_pkg::ADDR_CAUSE: begin
               st_d.sw = reg_wdata[pxu_pkg::CA_SW_LSB +: 2]; // RQ18
            end
            pxu_pkg::ADDR_EPC: begin
               st_d.exception_return_pointer = reg_wdata;
            end
            default: begin
            end
         endcase
      end

      // Exception entry overwrites status stack, cause and return pointer
      // A status write in the same cycle keeps its cu and im, but its mode stack loses to the entry push
      if (take) begin // RQ20
         st_d.fault = 1'b1; // RQ22
         st_d.redirect = pxu_pkg::GEN_VECTOR; // RQ8
         st_d.code = take_code;
         st_d.bd = ex_in_delay_slot; // RQ5
         st_d.exception_return_pointer = ex_in_delay_slot ? ex_branch_pc : ex_pc; // RQ5
         st_d.kuie = {st_q.kuie[3:0], 2'b00}; // RQ6
         if (take_code == pxu_pkg::CODE_UNIT_UNUSABLE) begin
            st_d.ce = cop_unit; // RQ15
         end
         if (take_badva) begin
            st_d.badva = badva_val; // RQ4
         end
      end else if (ex_valid && is_rfe) begin
         // Pop: previous to current, old to previous, old kept
         st_d.kuie = {st_q.kuie[5:4], st_q.kuie[5:2]}; // RQ21
      end

      // Read data stand in the cycle after the strobe
      st_d.rdata = 32'h0000_0000;
      if (reg_rd) begin
         unique case (reg_addr)
            pxu_pkg::ADDR_STATUS: st_d.rdata = status_word;
            pxu_pkg::ADDR_CAUSE: st_d.rdata = cause_word;
            pxu_pkg::ADDR_EPC: st_d.rdata = st_q.exception_return_pointer;
            pxu_pkg::ADDR_BADVA: st_d.rdata = st_q.badva;
            default: st_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '{
            cu: pxu_pkg::RST_CU,
            im: pxu_pkg::RST_IM,
            kuie: pxu_pkg::RST_KUIE,
            bd: 1'b0,
            ce: 2'h0,
            sw: 2'h0,
            code: pxu_pkg::RST_CODE,
            exception_return_pointer: 32'h0000_0000,
            badva: 32'h0000_0000,
            be_fetch: 1'b0,
            be_data: 1'b0,
            ack: 1'b0,
            fault: 1'b0,
            redirect: pxu_pkg::GEN_VECTOR,
            irq_req: 1'b0,
            rdata: 32'h0000_0000
         };
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   // User mode drops together with ex_fault_q, one cycle after ex_valid, since it reads the registered stack
   assign ex_ack_q = st_q.ack;
   assign ex_fault_q = st_q.fault;
   assign redirect_pc_q = st_q.redirect;
   assign user_mode_q = st_q.kuie[pxu_pkg::KU_CUR];
   assign irq_request_q = st_q.irq_req;
   assign reg_rdata_q = st_q.rdata;
endmodule
`default_nettype wire

// >>> verilog/pxu_pkg.sv
// Purpose: Shared constants for the processor exception unit
// Assumes: Registers are 32-bit words reached over a plain strobe port
// Notes: Cause codes and the vector are named here and used by name only in the design
package pxu_pkg;
   // Register byte addresses on the software port
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CAUSE = 4'h4;
   localparam logic [3:0] ADDR_EPC = 4'h8;
   localparam logic [3:0] ADDR_BADVA = 4'hC;
   // Status field positions
   localparam int ST_CU_LSB = 28;
   localparam int ST_IM_LSB = 8;
   localparam int ST_KUIE_LSB = 0;
   // Cause field positions
   localparam int CA_BD_POS = 31;
   localparam int CA_CE_LSB = 28;
   localparam int CA_IP_LSB = 10;
   localparam int CA_SW_LSB = 8;
   localparam int CA_CODE_LSB = 2;
   // Stack bit positions inside the six-bit mode stack
   localparam int KU_CUR = 1;
   localparam int IE_CUR = 0;
   // Reset values
   localparam logic [3:0] RST_CU = 4'h0;
   localparam logic [7:0] RST_IM = 8'h00;
   localparam logic [5:0] RST_KUIE = 6'h00;
   localparam logic [4:0] RST_CODE = 5'h00;
   // Cause codes
   localparam logic [4:0] CODE_INT = 5'h00;
   localparam logic [4:0] CODE_LOAD_FETCH_MISALIGN = 5'h04;
   localparam logic [4:0] CODE_STORE_MISALIGN = 5'h05;
   localparam logic [4:0] CODE_FETCH_BUS_ERR = 5'h06;
   localparam logic [4:0] CODE_DATA_BUS_ERR = 5'h07;
   localparam logic [4:0] CODE_TRAP = 5'h09;
   localparam logic [4:0] CODE_UNIT_UNUSABLE = 5'h0B;
   // General exception vector
   localparam logic [31:0] GEN_VECTOR = 32'h8000_0080;
   // Access sizes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   // Instruction decode fields
   localparam logic [5:0] OP_SPECIAL = 6'h00;
   localparam logic [5:0] FN_TRAP = 6'h0D;
   localparam logic [3:0] OP_COP_HI = 4'h4;
   localparam logic [5:0] OP_COP0 = 6'h10;
   localparam logic [5:0] FN_RETURN = 6'h10;
   // Number of synchronised pins: six interrupt lines and one bus error
   localparam int NUM_PINS = 7;
endpackage

// >>> verilog/pxu_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs are asynchronous to sys_clk
// Notes: Output changes only when the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module pxu_sync #(
   parameter int WIDTH = 7,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Pins in, clean levels out
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } pxu_sync_t;

   pxu_sync_t st_q;
   pxu_sync_t st_d;

   // Shift stages and update the filtered level per bit
   always_comb begin
      st_d = st_q;
      st_d.s1 = pin_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.lvl[i] = st_q.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
      end else begin
         st_q <= st_d;
      end
   end

   assign level_out = st_q.lvl;
endmodule
`default_nettype wire

// >>> verilog/pxu_addr_chk.sv
// Purpose: Alignment and privilege check of one virtual address
// Assumes: Size codes come from the shared package
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module pxu_addr_chk (
   // Access under test
   input wire logic [31:0] vaddr,
   input wire logic [1:0] size,
   input wire logic user_mode,
   // Verdict
   output logic bad
);
   logic misalign;
   logic kernel_hit;

   // Word needs two clear low bits, halfword one
   always_comb begin
      misalign = 1'b0;
      if (size == pxu_pkg::SIZE_WORD) begin
         misalign = vaddr[1] | vaddr[0]; // RQ1
      end else if (size == pxu_pkg::SIZE_HALF) begin
         misalign = vaddr[0]; // RQ1
      end
   end

   // Top half of the space is kernel only
   assign kernel_hit = user_mode & vaddr[31]; // RQ2
   assign bad = misalign | kernel_hit;
endmodule
`default_nettype wire

// >>> test/pxu_monitor.sv
// Purpose: Port checks for the exception unit
// Assumes: Bound to pxu_top, one clock domain
// Notes: Sees only the top module ports
`timescale 1ns/1ps
`default_nettype none
module pxu_monitor (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Exception stage
   input wire logic ex_valid,
   input wire logic [31:0] ex_pc,
   input wire logic [31:0] ex_instr,
   input wire logic ex_mem_rd,
   input wire logic ex_mem_wr,
   input wire logic [1:0] ex_mem_size,
   input wire logic [31:0] ex_mem_addr,
   // Answers
   input wire logic ex_ack_q,
   input wire logic ex_fault_q,
   input wire logic [31:0] redirect_pc_q,
   input wire logic user_mode_q,
   input wire logic irq_request_q,
   // Register port
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Answer timing and vector
   AST_ACK: assert property (ex_valid |=> ex_ack_q)
      else $error("no ack after instruction");
   AST_IDLE: assert property (!ex_valid |=> !ex_ack_q && !ex_fault_q)
      else $error("answer without instruction");
   AST_VECTOR: assert property (redirect_pc_q == pxu_pkg::GEN_VECTOR)
      else $error("wrong vector");
   // Address faults
   AST_FETCH_ALIGN: assert property (ex_valid && ex_pc[1:0] != 2'h0 |=> ex_fault_q)
      else $error("misaligned fetch not faulted");
   AST_DATA_ALIGN: assert property (
      ex_valid && (ex_mem_rd || ex_mem_wr) && ((ex_mem_size == pxu_pkg::SIZE_WORD && ex_mem_addr[1:0] != 2'h0)
      || (ex_mem_size == pxu_pkg::SIZE_HALF && ex_mem_addr[0])) |=> ex_fault_q)
      else $error("misaligned data not faulted");
   AST_KERNEL_ADDR: assert property (
      ex_valid && user_mode_q && (ex_mem_rd || ex_mem_wr) && ex_mem_addr[31] |=> ex_fault_q)
      else $error("user kernel access not faulted");
   // Trap and entry effects, read data timing
   AST_TRAP: assert property (
      ex_valid && ex_instr[31:26] == pxu_pkg::OP_SPECIAL && ex_instr[5:0] == pxu_pkg::FN_TRAP |=> ex_fault_q)
      else $error("trap not taken");
   AST_ENTRY: assert property (ex_fault_q |-> ##1 !irq_request_q && !user_mode_q)
      else $error("entry left user mode or enable");
   AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0000_0000)
      else $error("read data outside its cycle");
endmodule
`default_nettype wire

// >>> test/pxu_ext_model.sv
// Purpose: Interrupt sources and bus error logic outside the unit
// Assumes: Bench pulses set and clear commands
// Notes: Lines are pulled up while idle
`timescale 1ns/1ps
`default_nettype none
module pxu_ext_model (
   // Clock
   input wire logic sys_clk,
   // Bench commands
   input wire logic [5:0] irq_set,
   input wire logic [5:0] irq_clr,
   input wire logic berr_cmd,
   // Read activity on the bus
   input wire logic rd_busy,
   // Pins toward the unit
   output logic bus_err_n,
   output logic [5:0] hw_irq_n
);
   logic [5:0] held_q = 6'h00;
   // Requests stay up until the source condition is cleared
   always @(posedge sys_clk) begin
      held_q <= (held_q | irq_set) & ~irq_clr;
   end
   assign hw_irq_n = ~held_q;
   // Bus error only inside a read, buffered write faults never come here
   assign bus_err_n = !(berr_cmd && rd_busy);
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Purpose: Self-checking bench of the exception unit
// Assumes: Register port answers one cycle after the read strobe
// Notes: Each case programs status, issues one instruction, reads back if it faulted
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
   logic sys_clk = 1'h0, rst = 1'h1, ex_valid = 1'h0, ex_in_delay_slot = 1'h0, ex_mem_rd = 1'h0, ex_mem_wr = 1'h0;
   logic rd_fetch_active = 1'h0, rd_data_active = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, berr_cmd = 1'h0;
   logic [31:0] ex_pc = '0, ex_instr = '0, ex_branch_pc = '0, ex_mem_addr = '0, reg_wdata = '0, v;
   logic [1:0] ex_mem_size = '0;
   logic [3:0] reg_addr = '0;
   logic [5:0] irq_set = '0, irq_clr = '0;
   logic bus_err_n, ex_ack_q, ex_fault_q, user_mode_q, irq_request_q;
   logic [5:0] hw_irq_n;
   logic [31:0] redirect_pc_q, reg_rdata_q;
   int error_cnt = 0, cmp_count = 0;
   // Unit and far-side model
   pxu_top dut_u (.sys_clk, .rst, .ex_valid, .ex_pc, .ex_instr, .ex_in_delay_slot, .ex_branch_pc, .ex_mem_rd,
      .ex_mem_wr, .ex_mem_size, .ex_mem_addr, .rd_fetch_active, .rd_data_active, .bus_err_n, .hw_irq_n, .ex_ack_q,
      .ex_fault_q, .redirect_pc_q, .user_mode_q, .irq_request_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q);
   pxu_ext_model ext_u (.sys_clk, .irq_set, .irq_clr, .berr_cmd, .rd_busy(rd_fetch_active | rd_data_active),
      .bus_err_n, .hw_irq_n);
   always #2 sys_clk = ~sys_clk;
   // Register port cycles
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1;
      d = reg_rdata_q;
   endtask
   // Program status, issue one instruction, check the entry record
   task automatic run(input logic [31:0] st, pc, ins, input logic ds, input logic [1:0] rw,
      input logic [1:0] sz, input logic [31:0] ma, input logic ef, input logic [4:0] code);
      logic [31:0] r;
      bus_wr(pxu_pkg::ADDR_STATUS, st);
      @(posedge sys_clk);
      ex_valid <= 1'h1;
      ex_pc <= pc;
      ex_instr <= ins;
      ex_in_delay_slot <= ds;
      ex_branch_pc <= pc - 32'h0000_0004;
      {ex_mem_rd, ex_mem_wr} <= rw;
      ex_mem_size <= sz;
      ex_mem_addr <= ma;
      @(posedge sys_clk);
      ex_valid <= 1'h0;
      #1;
      `CHK("fault", ef, ex_fault_q)
      `CHK("ack", 1'h1, ex_ack_q)
      if (ef) begin
         `CHK("vector", pxu_pkg::GEN_VECTOR, redirect_pc_q)
         bus_rd(pxu_pkg::ADDR_CAUSE, r);
         `CHK("code", code, r[6:2])
         `CHK("delay", ds, r[31])
         if (code == pxu_pkg::CODE_UNIT_UNUSABLE) `CHK("unit", ins[27:26], r[29:28])
         bus_rd(pxu_pkg::ADDR_EPC, r);
         `CHK("epc", ds ? pc - 32'h0000_0004 : pc, r)
         bus_rd(pxu_pkg::ADDR_STATUS, r);
         `CHK("stack", st[5:0] << 2, r[5:0])
         if (code inside {pxu_pkg::CODE_LOAD_FETCH_MISALIGN, pxu_pkg::CODE_STORE_MISALIGN}) begin
            bus_rd(pxu_pkg::ADDR_BADVA, r);
            `CHK("badva", pc[1:0] != 2'h0 ? pc : ma, r)
         end
      end
   endtask
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      print_verdict();
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'h0;
      bus_wr(4'h2, 32'hFFFF_FFFF);
      bus_wr(pxu_pkg::ADDR_BADVA, 32'hFFFF_FFFF);
      for (int i = 0; i < 16; i += 2) begin
         bus_rd(4'(i), v);
         `CHK("reset", 32'h0000_0000, v)
      end
      run(32'h0000_0005, 32'h0000_1002, 32'h0000_0000, 1'h0, 2'h0, 2'h0, 32'h0000_0000, 1'h1, 5'h04);
      run(32'h0000_000E, 32'h0000_1004, 32'h0000_0000, 1'h0, 2'h2, 2'h2, 32'h0000_2001, 1'h1, 5'h04);
      run(32'h0000_0000, 32'h0000_1008, 32'h0000_0000, 1'h1, 2'h1, 2'h1, 32'h0000_3003, 1'h1, 5'h05);
      run(32'h0000_0000, 32'h0000_100C, 32'h0000_0000, 1'h0, 2'h1, 2'h2, 32'h0000_3006, 1'h1, 5'h05);
      run(32'h0000_0002, 32'h0000_1010, 32'h0000_0000, 1'h0, 2'h2, 2'h2, 32'h8000_0010, 1'h1, 5'h04);
      run(32'h0000_0000, 32'h0000_1014, 32'h0000_0000, 1'h0, 2'h2, 2'h2, 32'h8000_0010, 1'h0, 5'h00);
      run(32'h0000_0000, 32'h0000_1018, 32'h0000_0000, 1'h0, 2'h2, 2'h0, 32'h0000_0003, 1'h0, 5'h00);
      run(32'h0000_0002, 32'h0000_101C, 32'h03FF_FFCD, 1'h1, 2'h0, 2'h0, 32'h0000_0000, 1'h1, 5'h09);
      run(32'h0000_0002, 32'h0000_1020, 32'h4400_0000, 1'h0, 2'h0, 2'h0, 32'h0000_0000, 1'h1, 5'h0B);
      run(32'h0000_0000, 32'h0000_1024, 32'h4C00_0000, 1'h0, 2'h0, 2'h0, 32'h0000_0000, 1'h1, 5'h0B);
      run(32'h0000_0002, 32'h0000_1028, 32'h4000_0000, 1'h0, 2'h0, 2'h0, 32'h0000_0000, 1'h1, 5'h0B);
      run(32'h0000_0000, 32'h0000_102C, 32'h4000_0000, 1'h0, 2'h0, 2'h0, 32'h0000_0000, 1'h0, 5'h00);
      run(32'h2000_0002, 32'h0000_1030, 32'h4400_0000, 1'h0, 2'h0, 2'h0, 32'h0000_0000, 1'h0, 5'h00);
      run(32'h0000_0002, 32'h0000_1034, 32'h0000_000D, 1'h0, 2'h0, 2'h0, 32'h0000_0000, 1'h1, 5'h09);
      run(32'h0000_0000, 32'h0000_1039, 32'h0000_0000, 1'h0, 2'h0, 2'h0, 32'h0000_0000, 1'h1, 5'h04);
      run(32'h0000_001C, 32'h0000_1040, 32'h4200_0010, 1'h0, 2'h0, 2'h0, 32'h0000_0000, 1'h0, 5'h00);
      bus_rd(pxu_pkg::ADDR_STATUS, v);
      `CHK("pop", 6'h17, v[5:0])
      `CHK("user", 1'h1, user_mode_q)
      // Bus error during a fetch read, then during a data read
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         {rd_fetch_active, rd_data_active} <= i == 0 ? 2'h2 : 2'h1;
         berr_cmd <= 1'h1;
         repeat (6) @(posedge sys_clk);
         {rd_fetch_active, rd_data_active, berr_cmd} <= 3'h0;
         repeat (6) @(posedge sys_clk);
         run(32'h0000_0000, 32'h0000_1100, 32'h0000_0000, 1'h0, 2'h0, 2'h2, 32'h0000_0000, 1'h1, 5'h06 + 5'(i));
      end
      // Hardware line two, masked, unmasked, disabled
      bus_wr(pxu_pkg::ADDR_STATUS, 32'h0000_0001);
      irq_set <= 6'h04;
      @(posedge sys_clk);
      irq_set <= 6'h00;
      repeat (8) @(posedge sys_clk);
      bus_rd(pxu_pkg::ADDR_CAUSE, v);
      `CHK("pending", 6'h04, v[15:10])
      `CHK("masked", 1'h0, irq_request_q)
      bus_wr(pxu_pkg::ADDR_STATUS, 32'h0000_1001);
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("request", 1'h1, irq_request_q)
      bus_wr(pxu_pkg::ADDR_STATUS, 32'h0000_1000);
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("disabled", 1'h0, irq_request_q)
      bus_wr(pxu_pkg::ADDR_CAUSE, 32'hFFFF_FFFF);
      run(32'h0000_1301, 32'h0000_1200, 32'h0000_0000, 1'h0, 2'h0, 2'h0, 32'h0000_0000, 1'h1, 5'h00);
      bus_rd(pxu_pkg::ADDR_CAUSE, v);
      `CHK("sources", 8'h13, v[15:8])
      bus_wr(pxu_pkg::ADDR_CAUSE, 32'h0000_0000);
      irq_clr <= 6'h04;
      @(posedge sys_clk);
      irq_clr <= 6'h00;
      repeat (8) @(posedge sys_clk);
      bus_rd(pxu_pkg::ADDR_CAUSE, v);
      `CHK("cleared", 8'h00, v[15:8])
      bus_wr(pxu_pkg::ADDR_STATUS, 32'h0000_0101);
      bus_wr(pxu_pkg::ADDR_CAUSE, 32'h0000_0100);
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("soft", 1'h1, irq_request_q)
      print_verdict();
   end
endmodule
bind pxu_top pxu_monitor mon_u (.sys_clk, .rst, .ex_valid, .ex_pc, .ex_instr, .ex_mem_rd, .ex_mem_wr, .ex_mem_size,
   .ex_mem_addr, .ex_ack_q, .ex_fault_q, .redirect_pc_q, .user_mode_q, .irq_request_q, .reg_rd, .reg_rdata_q);
`default_nettype wire
